// ---- rtl/dialling_pkg.sv ----
package dialling_pkg;

   // ======================================================================
   // Timing
   // ======================================================================
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned PAUSE_SEC = 3;
   localparam int unsigned PAUSE_CYCLES = PAUSE_SEC * CLK_HZ;
   localparam int unsigned MINUTE_SEC = 60;
   localparam int unsigned MINUTE_CYCLES = MINUTE_SEC * CLK_HZ;

   // ======================================================================
   // Record layout and codes
   // ======================================================================
   localparam logic [7:0] DIGIT_BYTES = 8'h0a;
   localparam logic [7:0] PTR_NONE = 8'hff;
   localparam logic [7:0] LABEL_RST = 8'h00;
   localparam logic [15:0] MIN_ALL_ONES = 16'hffff;
   localparam logic [15:0] MIN_ZERO = 16'h0000;
   localparam logic [15:0] TIMEOUT_RST = 16'hffff;
   localparam logic [3:0] NIB_MAX_DEC = 4'h9;
   localparam logic [3:0] NIB_HASH = 4'hb;
   localparam logic [3:0] NIB_SEP = 4'hc;
   localparam logic [3:0] NIB_WILD = 4'hd;
   localparam logic [3:0] NIB_SHIFT = 4'he;
   localparam logic [3:0] NIB_END = 4'hf;
   localparam logic [4:0] SHIFT_BASE = 5'h10;

   // ======================================================================
   // Types
   // ======================================================================
   typedef enum logic [3:0] {
      S_IDLE     = 4'h0,
      S_LABEL    = 4'h1,
      S_LEN      = 4'h3,
      S_TYPE     = 4'h2,
      S_DIGIT    = 4'h6,
      S_NIB      = 4'h7,
      S_WILD     = 4'h5,
      S_PAUSE    = 4'h4,
      S_SPARE    = 4'hc,
      S_PTR      = 4'hd,
      S_EXT_TYPE = 4'hf,
      S_EXT_CNT  = 4'he,
      S_EXT_NEXT = 4'ha,
      S_DONE     = 4'hb
   } parse_state_t;

   typedef struct packed {
      logic [15:0] tv;
      logic [15:0] mtv;
      logic mtv_present;
   } timer_cfg_t;

   typedef struct packed {
      logic valid;
      logic [3:0] code;
   } tone_t;

endpackage

// ---- rtl/dialling_record_decoder.sv ----
`timescale 1ns/1ps
module dialling_record_decoder #(
   parameter int unsigned PAUSE_CYC = dialling_pkg::PAUSE_CYCLES,
   parameter int unsigned MINUTE_CYC = dialling_pkg::MINUTE_CYCLES
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic start,
   input wire logic [7:0] label_x,
   input wire logic rec_valid,
   input wire logic [7:0] rec_byte,
   output logic rec_ready,
   input wire logic wild_valid,
   input wire logic [3:0] wild_digit,
   output logic wild_req,
   output dialling_pkg::tone_t tone,
   output logic pause_active,
   output logic shift_code_valid,
   output logic [4:0] shift_code,
   output logic ext_req,
   output logic [7:0] ext_ptr,
   output logic done,
   input wire logic [7:0] search_req_len,
   output logic [7:0] search_len,
   input wire dialling_pkg::timer_cfg_t timer_cfg,
   input wire logic timer_load,
   output logic [15:0] applied_timeout,
   output logic timeout_expired,
   output logic timeout_cfg_error
);

   // =========================================================================
   // Record parser and symbol sequencer
   // =========================================================================
   dialling_pkg::parse_state_t state, next_state;
   logic [7:0] x, next_x;
   logic [7:0] cnt, next_cnt;
   logic [7:0] byte_q, next_byte_q;
   logic hi, next_hi;
   logic in_ext, next_in_ext;
   logic ended, next_ended;
   logic sep_seen, next_sep_seen;
   logic shift, next_shift;
   logic [31:0] pcnt, next_pcnt;
   logic next_rec_ready, next_wild_req, next_pause_active, next_done;
   dialling_pkg::tone_t next_tone;
   logic next_shift_code_valid;
   logic [4:0] next_shift_code;
   logic next_ext_req;
   logic [7:0] next_ext_ptr;
   logic [7:0] next_search_len;
   logic accept, adv;
   logic [3:0] nib;

   assign accept = rec_valid && rec_ready;
   // The earlier digit of each byte sits in the low nibble.
   assign nib = hi ? byte_q[7:4] : byte_q[3:0];

   always_comb begin
      next_state = state;
      next_x = x;
      next_cnt = cnt;
      next_byte_q = byte_q;
      next_hi = hi;
      next_in_ext = in_ext;
      next_ended = ended;
      next_sep_seen = sep_seen;
      next_shift = shift;
      next_pcnt = pcnt;
      next_tone = '0;
      next_shift_code_valid = 1'b0;
      next_shift_code = shift_code;
      next_ext_req = 1'b0;
      next_ext_ptr = ext_ptr;
      adv = 1'b0;
      case (state)
         dialling_pkg::S_IDLE, dialling_pkg::S_DONE: begin
            if (start) begin
               // X is known before any record byte is parsed.
               next_x = label_x;
               next_cnt = 8'h00;
               next_in_ext = 1'b0;
               next_ended = 1'b0;
               next_sep_seen = 1'b0;
               next_shift = 1'b0;
               next_state = (label_x == 8'h00) ? dialling_pkg::S_LEN
                                                : dialling_pkg::S_LABEL;
            end
         end
         dialling_pkg::S_LABEL: begin
            if (accept) begin
               next_cnt = cnt + 8'h01;
               if (cnt + 8'h01 == x) begin
                  next_cnt = 8'h00;
                  next_state = dialling_pkg::S_LEN;
               end
            end
         end
         dialling_pkg::S_LEN: begin
            // The length byte adds nothing: end marks and the fixed
            // DIGIT_BYTES field already bound the digit string.
            if (accept) begin
               next_state = dialling_pkg::S_TYPE;
            end
         end
         dialling_pkg::S_TYPE, dialling_pkg::S_EXT_CNT: begin
            if (accept) begin
               next_cnt = 8'h00;
               next_state = dialling_pkg::S_DIGIT;
            end
         end
         dialling_pkg::S_DIGIT: begin
            if (accept) begin
               next_byte_q = rec_byte;
               next_hi = 1'b0;
               next_cnt = cnt + 8'h01;
               next_state = dialling_pkg::S_NIB;
            end
         end
         dialling_pkg::S_NIB: begin
            adv = 1'b1;
            if (ended) begin
               adv = 1'b1;
            end else if (nib == dialling_pkg::NIB_END) begin
               next_ended = 1'b1;
            end else if (shift) begin
               // Shifted codes are undefined, so they go out as a code
               // only, never as a tone.
               next_shift = 1'b0;
               next_shift_code_valid = 1'b1;
               next_shift_code = dialling_pkg::SHIFT_BASE + {1'b0, nib};
            end else if (nib <= dialling_pkg::NIB_HASH) begin
               next_tone.valid = 1'b1;
               next_tone.code = nib;
            end else if (nib == dialling_pkg::NIB_SEP) begin
               next_sep_seen = 1'b1;
               if (sep_seen) begin
                  adv = 1'b0;
                  next_pcnt = 32'h0000_0000;
                  next_state = dialling_pkg::S_PAUSE;
               end
            end else if (nib == dialling_pkg::NIB_WILD) begin
               adv = 1'b0;
               next_state = dialling_pkg::S_WILD;
            end else begin
               next_shift = 1'b1;
            end
         end
         dialling_pkg::S_WILD: begin
            // Only decimal digits are taken from the user; anything else
            // keeps the request standing.
            if (wild_valid && wild_digit <= dialling_pkg::NIB_MAX_DEC) begin
               next_tone.valid = 1'b1;
               next_tone.code = wild_digit;
               adv = 1'b1;
            end
         end
         dialling_pkg::S_PAUSE: begin
            next_pcnt = pcnt + 32'h0000_0001;
            if (pcnt == 32'(PAUSE_CYC - 1)) begin
               adv = 1'b1;
            end
         end
         dialling_pkg::S_SPARE: begin
            if (accept) begin
               next_state = dialling_pkg::S_PTR;
            end
         end
         dialling_pkg::S_PTR, dialling_pkg::S_EXT_NEXT: begin
            if (accept) begin
               if (rec_byte != dialling_pkg::PTR_NONE) begin
                  next_ext_req = 1'b1;
                  next_ext_ptr = rec_byte;
                  next_in_ext = 1'b1;
                  next_state = dialling_pkg::S_EXT_TYPE;
               end else begin
                  next_state = dialling_pkg::S_DONE;
               end
            end
         end
         dialling_pkg::S_EXT_TYPE: begin
            if (accept) begin
               next_state = dialling_pkg::S_EXT_CNT;
            end
         end
         default: begin
            next_state = dialling_pkg::S_IDLE;
         end
      endcase
      if (adv) begin
         if (!hi) begin
            next_hi = 1'b1;
            next_state = dialling_pkg::S_NIB;
         end else if (cnt == dialling_pkg::DIGIT_BYTES) begin
            next_state = in_ext ? dialling_pkg::S_EXT_NEXT
                                : dialling_pkg::S_SPARE;
         end else begin
            next_state = dialling_pkg::S_DIGIT;
         end
      end
      case (next_state)
         dialling_pkg::S_IDLE, dialling_pkg::S_NIB, dialling_pkg::S_WILD,
         dialling_pkg::S_PAUSE, dialling_pkg::S_DONE: begin
            next_rec_ready = 1'b0;
         end
         default: begin
            next_rec_ready = 1'b1;
         end
      endcase
      next_wild_req = (next_state == dialling_pkg::S_WILD);
      next_pause_active = (next_state == dialling_pkg::S_PAUSE);
      next_done = (next_state == dialling_pkg::S_DONE);
      // The user interface may allow longer entries than the label holds.
      next_search_len = (search_req_len > x) ? x : search_req_len;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state <= dialling_pkg::S_IDLE;
         x <= dialling_pkg::LABEL_RST;
         cnt <= 8'h00;
         byte_q <= 8'h00;
         hi <= 1'b0;
         in_ext <= 1'b0;
         ended <= 1'b0;
         sep_seen <= 1'b0;
         shift <= 1'b0;
         pcnt <= 32'h0000_0000;
         rec_ready <= 1'b0;
         wild_req <= 1'b0;
         pause_active <= 1'b0;
         done <= 1'b0;
         tone <= '0;
         shift_code_valid <= 1'b0;
         shift_code <= 5'h00;
         ext_req <= 1'b0;
         ext_ptr <= dialling_pkg::PTR_NONE;
         search_len <= 8'h00;
      end else if (ce) begin
         state <= next_state;
         x <= next_x;
         cnt <= next_cnt;
         byte_q <= next_byte_q;
         hi <= next_hi;
         in_ext <= next_in_ext;
         ended <= next_ended;
         sep_seen <= next_sep_seen;
         shift <= next_shift;
         pcnt <= next_pcnt;
         rec_ready <= next_rec_ready;
         wild_req <= next_wild_req;
         pause_active <= next_pause_active;
         done <= next_done;
         tone <= next_tone;
         shift_code_valid <= next_shift_code_valid;
         shift_code <= next_shift_code;
         ext_req <= next_ext_req;
         ext_ptr <= next_ext_ptr;
         search_len <= next_search_len;
      end
   end

   // =========================================================================
   // Session timer
   // =========================================================================
   logic [31:0] pre, next_pre;
   logic [15:0] minutes, next_minutes;
   logic [15:0] next_applied;
   logic next_expired, next_cfg_error, limit_on;

   // A zero or all-ones maximum, or a missing file, gives no limit.
   assign limit_on = timer_cfg.mtv_present &&
                     timer_cfg.mtv != dialling_pkg::MIN_ZERO &&
                     timer_cfg.mtv != dialling_pkg::MIN_ALL_ONES;

   always_comb begin
      next_pre = pre;
      next_minutes = minutes;
      next_applied = applied_timeout;
      next_expired = timeout_expired;
      next_cfg_error = timeout_cfg_error;
      if (timer_load) begin
         next_pre = 32'h0000_0000;
         next_minutes = dialling_pkg::MIN_ZERO;
         next_expired = 1'b0;
         next_cfg_error = timer_cfg.tv == dialling_pkg::MIN_ZERO ||
            (timer_cfg.mtv_present &&
             timer_cfg.mtv == dialling_pkg::MIN_ZERO);
         // A zero timeout is refused and the previous value stays.
         if (timer_cfg.tv != dialling_pkg::MIN_ZERO) begin
            next_applied = (limit_on && timer_cfg.tv > timer_cfg.mtv) ?
                           timer_cfg.mtv : timer_cfg.tv;
         end
      end else if (applied_timeout != dialling_pkg::MIN_ALL_ONES &&
                   !timeout_expired) begin
         next_pre = pre + 32'h0000_0001;
         if (pre == 32'(MINUTE_CYC - 1)) begin
            next_pre = 32'h0000_0000;
            next_minutes = minutes + 16'h0001;
            if (minutes + 16'h0001 == applied_timeout) begin
               next_expired = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pre <= 32'h0000_0000;
         minutes <= dialling_pkg::MIN_ZERO;
         applied_timeout <= dialling_pkg::TIMEOUT_RST;
         timeout_expired <= 1'b0;
         timeout_cfg_error <= 1'b0;
      end else if (ce) begin
         pre <= next_pre;
         minutes <= next_minutes;
         applied_timeout <= next_applied;
         timeout_expired <= next_expired;
         timeout_cfg_error <= next_cfg_error;
      end
   end

   // =========================================================================
   // Checks
   // =========================================================================
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b || !ce);

   chk_no_ctrl_tone: assert property (
      tone.valid |-> tone.code <= dialling_pkg::NIB_HASH)
      else $error("tone emitted for a control nibble");
   chk_digit_decode: assert property (
      state == dialling_pkg::S_NIB && !ended && !shift &&
      nib <= dialling_pkg::NIB_HASH |=> tone.valid && tone.code == $past(nib))
      else $error("digit nibble not sent as its tone");
   chk_wild_prompt: assert property (
      state == dialling_pkg::S_NIB && !ended && !shift &&
      nib == dialling_pkg::NIB_WILD |=> wild_req && !tone.valid)
      else $error("wildcard did not prompt the user");
   chk_end_mark: assert property (
      ended |-> !tone.valid)
      else $error("tone after end mark");
   chk_pause_sep: assert property (
      state == dialling_pkg::S_NIB && !ended && !shift && sep_seen &&
      nib == dialling_pkg::NIB_SEP |=> pause_active [*2])
      else $error("repeated separator gave no pause");
   chk_shift_code: assert property (
      state == dialling_pkg::S_NIB && !ended && shift &&
      nib != dialling_pkg::NIB_END |=> shift_code_valid && !tone.valid &&
      shift_code == dialling_pkg::SHIFT_BASE + {1'b0, $past(nib)})
      else $error("shifted digit mishandled");
   chk_spare_skip: assert property (
      state == dialling_pkg::S_SPARE && accept |=>
      state == dialling_pkg::S_PTR && !ext_req)
      else $error("spare byte was interpreted");
   chk_overflow_req: assert property (
      state == dialling_pkg::S_PTR && accept &&
      rec_byte != dialling_pkg::PTR_NONE |=> ext_req && ext_ptr == $past(rec_byte))
      else $error("overflow pointer not followed");
   chk_chain_end: assert property (
      state == dialling_pkg::S_EXT_NEXT && accept &&
      rec_byte == dialling_pkg::PTR_NONE |=> done && !ext_req)
      else $error("chain did not stop at all ones");
   chk_low_first: assert property (
      state == dialling_pkg::S_DIGIT && accept |=> !hi ##1 hi || !ended)
      else $error("nibble order wrong");
   chk_search_cap: assert property (
      1'b1 |=> search_len <= $past(x) &&
      search_len <= $past(search_req_len))
      else $error("search string longer than label");
   chk_max_limit: assert property (
      timer_load && limit_on && timer_cfg.tv != dialling_pkg::MIN_ZERO |=>
      applied_timeout <= $past(timer_cfg.mtv))
      else $error("applied timeout above maximum");
   chk_zero_refused: assert property (
      timer_load && timer_cfg.tv == dialling_pkg::MIN_ZERO |=>
      timeout_cfg_error && $stable(applied_timeout))
      else $error("zero timeout was applied");
   chk_no_expiry_off: assert property (
      timeout_expired |-> applied_timeout != dialling_pkg::MIN_ALL_ONES &&
      minutes == applied_timeout)
      else $error("expiry without reaching timeout");

   cov_wild: cover property (wild_req ##1 tone.valid);
   cov_pause: cover property ($fell(pause_active));
   cov_chain: cover property (ext_req ##[1:300] ext_req);
   cov_done: cover property ($rose(done));

endmodule

// ---- verification/card_model.sv ----
`timescale 1ns/1ps
// ======================================================================
// Card record source
// ======================================================================
// A line the card has let go shows the inverse of its last value, so a
// byte taken out of turn shows up as a wrong digit, or as a repeat after an even number of idle edges.
module card_model (
   input wire logic mclk,
   input wire logic ce,
   input wire logic rec_ready,
   output logic rec_valid,
   output logic [7:0] rec_byte
);
   logic [7:0] q[$];
   logic taken;
   initial begin
      rec_valid = 1'b0;
      rec_byte = 8'h00;
   end
   task automatic push(input logic [7:0] b);
      q.push_back(b);
   endtask
   always @(posedge mclk) begin
      // A byte offered on a frozen edge is not taken by the block.
      taken = rec_valid && (rec_ready === 1'b1) && (ce === 1'b1);
      #1;
      if (taken) void'(q.pop_front());
      if (!rec_valid || taken) begin
         if (q.size() > 0 && $urandom_range(3) != 0) begin
            rec_valid = 1'b1;
            rec_byte = q[0];
         end else begin
            rec_valid = 1'b0;
            rec_byte = ~rec_byte;
         end
      end
   end
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   localparam int unsigned PC = 20;
   localparam int unsigned MC = 10;
   logic mclk, rst_b, ce, start, rec_valid, rec_ready, wild_valid, wild_req;
   logic [7:0] label_x, rec_byte, ext_ptr, search_req_len, search_len;
   logic [3:0] wild_digit;
   logic pause_active, shift_code_valid, ext_req, done, shifted, ended;
   logic [4:0] shift_code;
   logic timer_load, timeout_expired, timeout_cfg_error;
   logic [15:0] applied_timeout;
   logic [15:0] q_tone[$], q_shift[$], q_ext[$], q_pause[$];
   dialling_pkg::tone_t tone;
   dialling_pkg::timer_cfg_t timer_cfg;
   int n_fail, num_checks, seps, plen;
   bit ce_rand, ce_go;
   dialling_record_decoder #(.PAUSE_CYC(PC), .MINUTE_CYC(MC))
      dialling_record_decoder_inst (.mclk(mclk), .rst_b(rst_b), .ce(ce),
      .start(start), .label_x(label_x), .rec_valid(rec_valid),
      .rec_byte(rec_byte), .rec_ready(rec_ready), .wild_valid(wild_valid),
      .wild_digit(wild_digit), .wild_req(wild_req), .tone(tone),
      .pause_active(pause_active), .shift_code_valid(shift_code_valid),
      .shift_code(shift_code), .ext_req(ext_req), .ext_ptr(ext_ptr),
      .done(done), .search_req_len(search_req_len),
      .search_len(search_len), .timer_cfg(timer_cfg),
      .timer_load(timer_load), .applied_timeout(applied_timeout),
      .timeout_expired(timeout_expired),
      .timeout_cfg_error(timeout_cfg_error));
   card_model card_model_inst (.mclk(mclk), .ce(ce), .rec_ready(rec_ready),
      .rec_valid(rec_valid), .rec_byte(rec_byte));
   // ===================================================================
   // Checking
   // ===================================================================
   task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_flag(input logic got, input logic exp);
      cmp16({15'h0, got}, {15'h0, exp});
   endtask
   task automatic results;
      $display("checks=%0d fails=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // An unexpected pulse pops a value that no narrow output can match.
   // Only enabled edges count, so an output frozen by ce counts once.
   always @(posedge mclk) begin
      if (ce === 1'b1) begin
         if (tone.valid === 1'b1)
            cmp16({12'h0, tone.code}, q_tone.size() ? q_tone.pop_front()
               : 16'hdead);
         if (shift_code_valid === 1'b1)
            cmp16({11'h0, shift_code}, q_shift.size() ? q_shift.pop_front()
               : 16'hdead);
         if (ext_req === 1'b1)
            cmp16({8'h0, ext_ptr}, q_ext.size() ? q_ext.pop_front()
               : 16'hdead);
         if (pause_active === 1'b1) plen++;
         else if (plen > 0) begin
            cmp16(16'(plen), q_pause.size() ? q_pause.pop_front()
               : 16'hdead);
            plen = 0;
         end
      end
   end
   // The start edge always runs with ce high, or the record is lost.
   always @(posedge mclk) begin
      #1;
      wild_valid = (wild_req === 1'b1);
      ce = !ce_go || ($urandom_range(7) != 0);
   end
   // ===================================================================
   // Stimulus and expectations
   // ===================================================================
   task automatic nib(input logic [3:0] n);
      if (ended) return;
      if (n == dialling_pkg::NIB_END) ended = 1'b1;
      else if (shifted) begin
         q_shift.push_back(16'h0010 + n);
         shifted = 1'b0;
      end else if (n <= dialling_pkg::NIB_HASH) q_tone.push_back({12'h0, n});
      else if (n == dialling_pkg::NIB_SEP) begin
         if (seps > 0) q_pause.push_back(16'(PC));
         seps++;
      end else if (n == dialling_pkg::NIB_WILD)
         q_tone.push_back({12'h0, wild_digit});
      else shifted = 1'b1;
   endtask
   task automatic digits(input logic [3:0] n[$]);
      while (n.size() < 20) n.push_back(dialling_pkg::NIB_END);
      for (int i = 0; i < 20; i += 2) begin
         nib(n[i]);
         nib(n[i+1]);
         card_model_inst.push({n[i+1], n[i]});
      end
   endtask
   task automatic wait_for(input bit ext);
      int k;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (((ext ? ext_req : done) !== 1'b1) && k < 3000);
      cmp_flag(k < 3000, 1'b1);
   endtask
   task automatic rec(input logic [7:0] x, input logic [3:0] n[$],
         input logic [7:0] ptr);
      ce_go = 1'b0;
      @(posedge mclk);
      #1;
      start = 1'b1;
      label_x = x;
      wild_digit = 4'($urandom_range(9));
      seps = 0;
      shifted = 1'b0;
      ended = 1'b0;
      @(posedge mclk);
      #1;
      start = 1'b0;
      ce_go = ce_rand;
      for (int i = 0; i < x; i++)
         card_model_inst.push(i + 1 < x ? 8'(8'h41 + i) : 8'hff);
      card_model_inst.push(8'h0b);
      card_model_inst.push(8'($urandom));
      digits(n);
      card_model_inst.push(8'($urandom));
      card_model_inst.push(ptr);
      if (ptr != 8'hff) q_ext.push_back({8'h0, ptr});
      wait_for(ptr != 8'hff);
   endtask
   task automatic ext(input logic [3:0] n[$], input logic [7:0] nxt);
      card_model_inst.push(8'h02);
      card_model_inst.push(8'h0b);
      digits(n);
      card_model_inst.push(nxt);
      if (nxt != 8'hff) q_ext.push_back({8'h0, nxt});
      wait_for(nxt != 8'hff);
   endtask
   task automatic endchk;
      repeat (3) @(posedge mclk);
      cmp16(16'(q_tone.size() + q_shift.size() + q_pause.size()),
         16'h0);
   endtask
   task automatic tload(input logic [15:0] tv, input logic [15:0] mtv,
         input logic pres, input logic [15:0] ea, input logic err);
      @(posedge mclk);
      #1;
      timer_cfg = '{tv: tv, mtv: mtv, mtv_present: pres};
      timer_load = 1'b1;
      @(posedge mclk);
      #1;
      timer_load = 1'b0;
      cmp16(applied_timeout, ea);
      cmp_flag(timeout_cfg_error, err);
      if (ea == 16'hffff) begin
         repeat (100) @(posedge mclk);
         cmp_flag(timeout_expired, 1'b0);
      end else if (!err) begin
         repeat (int'(ea) * MC - 2) @(posedge mclk);
         cmp_flag(timeout_expired, 1'b0);
         repeat (4) @(posedge mclk);
         cmp_flag(timeout_expired, 1'b1);
      end
   endtask
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   initial begin
      #(20000 * 50);
      n_fail++;
      results();
   end
   initial begin
      logic [3:0] r[$];
      {rst_b, start, timer_load} = 3'h0;
      {label_x, wild_digit, search_req_len} = 20'h0;
      {ce_rand, ce_go} = 2'b00;
      timer_cfg = '0;
      void'($urandom(18249));
      repeat (5) @(posedge mclk);
      #1;
      rst_b = 1'b1;
      cmp16({ext_ptr, 7'h0, done}, 16'hff00);
      cmp16(applied_timeout, 16'hffff);
      rec(0, '{1, 2, 3, 4, 5, 6, 7, 8, 9, 0, 4'ha, 4'hb, 4'hf, 7},
         8'hff);
      endchk();
      rec(3, '{4'hc, 1, 4'hc, 2, 4'hd, 4'he, 3, 4'hc, 4'hc, 4, 4'hb},
         8'hff);
      endchk();
      for (int i = 0; i < 8; i++) begin
         @(posedge mclk);
         #1;
         search_req_len = 8'($urandom_range(6));
         repeat (2) @(posedge mclk);
         #1;
         cmp16({8'h0, search_len}, search_req_len < 3 ? search_req_len
            : 16'h3);
      end
      for (int i = 0; i < 20; i++) r.push_back(4'($urandom_range(9)));
      rec(0, r, 8'h05);
      ext(r, 8'h07);
      ext('{1, 2, 3, 4'hf}, 8'hff);
      endchk();
      // These records run with ce dropping at random after each start.
      ce_rand = 1'b1;
      for (int j = 0; j < 4; j++) begin
         r.delete();
         for (int i = 0; i < 1 + $urandom_range(19); i++)
            r.push_back(4'($urandom_range(12)));
         rec(8'($urandom_range(4)), r, 8'hff);
         endchk();
      end
      ce_rand = 1'b0;
      ce_go = 1'b0;
      tload(16'h0003, 16'h0001, 1'b0, 16'h0003, 1'b0);
      tload(16'h0005, 16'h0002, 1'b1, 16'h0002, 1'b0);
      tload(16'h0004, 16'hffff, 1'b1, 16'h0004, 1'b0);
      tload(16'hffff, 16'h0000, 1'b0, 16'hffff, 1'b0);
      tload(16'hffff, 16'h0006, 1'b1, 16'h0006, 1'b0);
      tload(16'h0000, 16'h0009, 1'b1, 16'h0006, 1'b1);
      tload(16'h0002, 16'h0000, 1'b1, 16'h0002, 1'b1);
      results();
   end
endmodule
